/* logic/qsfh_front.sv */
// Device-side serial interface front end: framing, lanes, pause, protection
//
// Functional notes
// - Single-line mode: bits arrive on line 0, captured at serial clock rise.
// - Single-line mode: read bits leave on line 1, changed at serial clock fall.
// - Dual/quad lines are two-way: capture on rise, drive on fall.
// - Quad operation needs the quad enable bit; quad-instruction mode checks it only on entry.
// - Quad enable turns protect and pause pins into data lines 2 and 3.
// - Chip select high: deselected, every data line floats.
// - Internal write cycles carry on after chip select rises.
// - Chip select low selects; instruction bytes taken, read data returned.
// - After power-up nothing is taken before a chip select fall.
// - Pause low while selected floats outputs, ignores data and clock.
// - Pause release resumes exactly where the transfer stood.
// - Protect pin low refuses status writes when protect bits pick hardware mode.
// - Protect bits select a refused region, one sector up to whole array.
// - Page program takes one up to page-size bytes.
// - Erase granularity: sector, two block sizes, or whole chip.
// - Quad-instruction mode takes each opcode on four lines in two clocks.
// - A 64-bit unique identifier is readable by the host.
// - Serial clock may idle low or high at chip select edges.
// - Pause acts with clock low, otherwise after the next clock fall.
// - Enter/exit opcodes switch quad-instruction mode; reset returns single mode.
`timescale 1ns/1ps
module qsfh_front #(
    parameter logic [63:0] UID_VALUE = qsfh_pkg::UID_DEFAULT, // Arbitrary value
    parameter int PROG_LIMIT = 256
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic serial_clk,
    input wire logic chip_sel_n,
    input wire logic io_line0_in,
    output logic io_line0_out,
    output logic io_line0_oe_n,
    input wire logic io_line1_in,
    output logic io_line1_out,
    output logic io_line1_oe_n,
    input wire logic io_line2_in,
    output logic io_line2_out,
    output logic io_line2_oe_n,
    input wire logic io_line3_in,
    output logic io_line3_out,
    output logic io_line3_oe_n,
    input wire logic quad_enable_bit,
    input wire logic [1:0] status_protect_bits,
    input wire logic complement_bit,
    input wire logic sector_granularity_bit,
    input wire logic top_bottom_bit,
    input wire logic block_protect_2,
    input wire logic block_protect_1,
    input wire logic block_protect_0,
    input wire qsfh_pkg::qsfh_lane_e lane_width,
    input wire logic tx_enable,
    input wire logic [7:0] tx_data,
    output logic tx_taken,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_is_opcode,
    input wire logic prog_data,
    output logic [8:0] prog_byte_count,
    output logic selected,
    output logic paused,
    output logic quad_instruction_mode,
    output logic frame_end,
    output logic sr_write_ok,
    input wire logic [qsfh_pkg::ADDR_W-1:0] check_addr,
    output logic addr_protected,
    input wire qsfh_pkg::qsfh_erase_e erase_kind,
    output logic [qsfh_pkg::ADDR_W-1:0] erase_base,
    input wire logic [2:0] uid_index,
    output logic [7:0] uid_byte
);
    import qsfh_pkg::*;

    if (PROG_LIMIT < 1 || PROG_LIMIT > 256) begin : g_bad_limit
        $error("PROG_LIMIT must lie in 1..256");
    end

    localparam logic [8:0] PROG_MAX = 9'(PROG_LIMIT);

    function automatic logic [2:0] lane_bits(input qsfh_lane_e w);
        unique case (w)
            LANE_DUAL: lane_bits = 3'h2;
            LANE_QUAD: lane_bits = 3'h4;
            default: lane_bits = 3'h1;
        endcase
    endfunction

    function automatic logic [2:0] lane_last(input qsfh_lane_e w);
        unique case (w)
            LANE_DUAL: lane_last = 3'h3;
            LANE_QUAD: lane_last = 3'h1;
            default: lane_last = 3'h7;
        endcase
    endfunction

    // Top or bottom region check; complement flips the sense
    function automatic logic prot_hit(input logic [ADDR_W-1:0] a, input logic [2:0] bp,
                                      input logic tb, input logic sec, input logic cmp);
        logic [2:0] sh;
        logic [4:0] amt;
        logic [19:0] sz;
        logic hit;
        sh = (bp - 3'h1 > SEC_SHIFT_MAX) ? SEC_SHIFT_MAX : bp - 3'h1;
        amt = (sec ? SECTOR_LSB : BLK64_LSB) + {2'h0, sh};
        sz = 20'h00001 << amt;
        if (bp == 3'h0) begin
            hit = 1'b0;
        end else if (tb) begin
            hit = {1'b0, a} < sz;
        end else begin
            hit = {1'b0, a} >= MEM_BYTES - sz;
        end
        prot_hit = hit ^ cmp;
    endfunction

    function automatic logic [4:0] erase_lsb(input qsfh_erase_e k);
        unique case (k)
            ER_BLK32: erase_lsb = BLK32_LSB;
            ER_BLK64: erase_lsb = BLK64_LSB;
            ER_CHIP: erase_lsb = CHIP_LSB;
            default: erase_lsb = SECTOR_LSB;
        endcase
    endfunction

    logic [5:0] s1_r, s2_r, s3_r, filt_r, filt_d_r;
    logic [5:0] pins;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, cs_low;
    qsfh_phase_e phase_r;
    logic seen_high_r, qpi_r, pause_r, drive_r;
    logic hold_func, wp_low;
    qsfh_lane_e width_eff;
    logic [7:0] rx_sh_r, rx_next, tx_sh_r, tx_src;
    logic [2:0] rx_cnt_r, tx_cnt_r;
    logic [3:0] io_out_r;
    logic rx_valid_r, rx_is_op_r, tx_taken_r, frame_end_r;
    logic [8:0] prog_cnt_r;
    logic sr_ok_r, prot_r;
    logic [ADDR_W-1:0] erase_base_r;
    logic [7:0] uid_r;

    // Three stages; a level counts once stages two and three agree
    assign pins = {chip_sel_n, serial_clk, io_line3_in, io_line2_in, io_line1_in, io_line0_in};

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s1_r <= SYNC_RESET;
            s2_r <= SYNC_RESET;
            s3_r <= SYNC_RESET;
            filt_r <= SYNC_RESET;
            filt_d_r <= SYNC_RESET;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
            filt_d_r <= filt_r;
        end
    end

    // Clock edges are found only while chip select is low, so either idle clock level works
    assign cs_low = ~filt_r[PIN_CSN];
    assign cs_fall = filt_d_r[PIN_CSN] & ~filt_r[PIN_CSN];
    assign cs_rise = ~filt_d_r[PIN_CSN] & filt_r[PIN_CSN];
    assign sclk_rise = cs_low & ~filt_d_r[PIN_SCLK] & filt_r[PIN_SCLK] & ~pause_r;
    assign sclk_fall = cs_low & filt_d_r[PIN_SCLK] & ~filt_r[PIN_SCLK] & ~pause_r;

    // Quad enable repurposes the protect and pause pins as data lines
    assign hold_func = ~quad_enable_bit & ~qpi_r;
    assign wp_low = ~quad_enable_bit & ~filt_r[PIN_IO2];

    // Quad lanes demote to single when quad enable is clear
    always_comb begin
        if (qpi_r) begin
            width_eff = LANE_QUAD;
        end else if (phase_r != PH_BODY) begin
            width_eff = LANE_SINGLE;
        end else if (lane_width == LANE_QUAD && !quad_enable_bit) begin
            width_eff = LANE_SINGLE;
        end else begin
            width_eff = lane_width;
        end
    end

    // Power-up arming: only a real high-to-low select starts a frame
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            seen_high_r <= 1'b0;
        end else if (filt_r[PIN_CSN]) begin
            seen_high_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= PH_IDLE;
        end else if (!cs_low) begin
            phase_r <= PH_IDLE;
        end else if (cs_fall && seen_high_r) begin
            phase_r <= PH_OPCODE;
        end else if (rx_valid_r && phase_r == PH_OPCODE) begin
            phase_r <= PH_BODY;
        end
    end

    // Pause follows the pin only while the clock is low
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pause_r <= 1'b0;
        end else if (!cs_low || !hold_func) begin
            pause_r <= 1'b0;
        end else if (!filt_r[PIN_SCLK]) begin
            pause_r <= ~filt_r[PIN_IO3];
        end
    end

    // Receive shifter; counters freeze during pause so release resumes in place
    always_comb begin
        unique case (width_eff)
            LANE_DUAL: rx_next = {rx_sh_r[5:0], filt_r[PIN_IO1], filt_r[PIN_IO0]};
            LANE_QUAD: rx_next = {rx_sh_r[3:0], filt_r[PIN_IO3:PIN_IO0]};
            default: rx_next = {rx_sh_r[6:0], filt_r[PIN_IO0]};
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_sh_r <= 8'h00;
            rx_cnt_r <= 3'h0;
            rx_valid_r <= 1'b0;
            rx_is_op_r <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            rx_valid_r <= 1'b0;
            if (phase_r == PH_IDLE) begin
                rx_cnt_r <= 3'h0;
            end else if (sclk_rise) begin
                rx_sh_r <= rx_next;
                if (rx_cnt_r == lane_last(width_eff)) begin
                    rx_cnt_r <= 3'h0;
                    rx_data <= rx_next;
                    rx_valid_r <= 1'b1;
                    rx_is_op_r <= phase_r == PH_OPCODE;
                end else begin
                    rx_cnt_r <= rx_cnt_r + 3'h1;
                end
            end
        end
    end

    // Mode switch acts on complete opcodes only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            qpi_r <= 1'b0;
        end else if (rx_valid_r && rx_is_op_r) begin
            if (rx_data == OP_QPI_ENTER && quad_enable_bit) begin
                qpi_r <= 1'b1;
            end else if (rx_data == OP_QPI_EXIT || rx_data == OP_SOFT_RESET) begin
                qpi_r <= 1'b0;
            end
        end
    end

    // Transmit: a fresh byte is taken whenever the shifter runs dry
    assign tx_src = (tx_cnt_r == 3'h0) ? tx_data : tx_sh_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_sh_r <= 8'h00;
            tx_cnt_r <= 3'h0;
            io_out_r <= 4'h0;
            drive_r <= 1'b0;
            tx_taken_r <= 1'b0;
        end else begin
            tx_taken_r <= 1'b0;
            if (phase_r == PH_IDLE) begin
                tx_cnt_r <= 3'h0;
                drive_r <= 1'b0;
            end else if (sclk_fall) begin
                drive_r <= tx_enable;
                if (tx_enable) begin
                    tx_sh_r <= tx_src << lane_bits(width_eff);
                    tx_taken_r <= tx_cnt_r == 3'h0;
                    tx_cnt_r <= (tx_cnt_r == 3'h0) ? lane_last(width_eff) : tx_cnt_r - 3'h1;
                    unique case (width_eff)
                        LANE_DUAL: io_out_r <= {2'h0, tx_src[7:6]};
                        LANE_QUAD: io_out_r <= tx_src[7:4];
                        default: io_out_r <= {2'h0, tx_src[7], 1'b0};
                    endcase
                end
            end
        end
    end

    // Lines float whenever deselected or paused
    assign io_line0_out = io_out_r[0];
    assign io_line1_out = io_out_r[1];
    assign io_line2_out = io_out_r[2];
    assign io_line3_out = io_out_r[3];
    assign io_line1_oe_n = ~(drive_r & cs_low & ~pause_r);
    assign io_line0_oe_n = ~(drive_r & cs_low & ~pause_r & width_eff != LANE_SINGLE);
    assign io_line2_oe_n = ~(drive_r & cs_low & width_eff == LANE_QUAD);
    assign io_line3_oe_n = ~(drive_r & cs_low & width_eff == LANE_QUAD);

    // Frame end only reports; an internal write cycle outside is never aborted
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            frame_end_r <= 1'b0;
        end else begin
            frame_end_r <= cs_rise;
        end
    end

    // Page program byte count saturates at PROG_LIMIT
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prog_cnt_r <= 9'h000;
        end else if (phase_r == PH_OPCODE) begin
            prog_cnt_r <= 9'h000;
        end else if (rx_valid_r && !rx_is_op_r && prog_data && prog_cnt_r < PROG_MAX) begin
            prog_cnt_r <= prog_cnt_r + 9'h001;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sr_ok_r <= 1'b0;
            prot_r <= 1'b1;
            erase_base_r <= '0;
            uid_r <= 8'h00;
        end else begin
            sr_ok_r <= !(status_protect_bits == SRP_HW && wp_low);
            prot_r <= prot_hit(check_addr, {block_protect_2, block_protect_1, block_protect_0},
                               top_bottom_bit, sector_granularity_bit, complement_bit);
            erase_base_r <= check_addr & ~((19'h00001 << erase_lsb(erase_kind)) - 19'h00001);
            uid_r <= 8'(UID_VALUE >> {uid_index, 3'h0});
        end
    end

    assign rx_valid = rx_valid_r;
    assign rx_is_opcode = rx_is_op_r;
    assign tx_taken = tx_taken_r;
    assign prog_byte_count = prog_cnt_r;
    assign selected = phase_r != PH_IDLE;
    assign paused = pause_r;
    assign quad_instruction_mode = qpi_r;
    assign frame_end = frame_end_r;
    assign sr_write_ok = sr_ok_r;
    assign addr_protected = prot_r;
    assign erase_base = erase_base_r;
    assign uid_byte = uid_r;

    chk_desel_float:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
        !cs_low |-> io_line0_oe_n && io_line1_oe_n && io_line2_oe_n && io_line3_oe_n)
        else $error("data line driven while deselected");

    chk_pause_float:
    assert property (@(posedge clk_sys) disable iff (!reset_n) pause_r |-> io_line1_oe_n && !rx_valid_r)
        else $error("activity during pause");

    chk_arm_first:
    assert property (@(posedge clk_sys) disable iff (!reset_n) !seen_high_r |-> phase_r == PH_IDLE)
        else $error("frame started before chip select was seen high");

    chk_qpi_needs_qe:
    assert property (@(posedge clk_sys) disable iff (!reset_n) $rose(qpi_r) |-> $past(quad_enable_bit))
        else $error("quad-instruction mode entered without quad enable");

    chk_wp_refuse:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
        (status_protect_bits == SRP_HW && wp_low) |=> !sr_ok_r)
        else $error("status write allowed under hardware protect");

    chk_frame_drop:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
        cs_rise |=> phase_r == PH_IDLE ##1 rx_cnt_r == 3'h0)
        else $error("partial instruction survived deselect");

    chk_byte_on_rise:
    assert property (@(posedge clk_sys) disable iff (!reset_n) rx_valid_r |-> $past(sclk_rise))
        else $error("byte completed without a clock rise");

    chk_single_lane:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
        width_eff == LANE_SINGLE |-> io_line0_oe_n && io_line2_oe_n)
        else $error("single mode drove the input line");

    chk_pause_timing:
    assert property (@(posedge clk_sys) disable iff (!reset_n) $rose(pause_r) |-> !$past(filt_r[PIN_SCLK]))
        else $error("pause started with clock high");
endmodule

/* shared/qsfh_pkg.sv */
// Constants and types for the serial flash device-side interface front end
package qsfh_pkg;
    typedef enum logic [1:0] {LANE_SINGLE = 2'h0, LANE_DUAL = 2'h1, LANE_QUAD = 2'h2} qsfh_lane_e;
    typedef enum logic [1:0] {PH_IDLE = 2'h0, PH_OPCODE = 2'h1, PH_BODY = 2'h3} qsfh_phase_e;
    typedef enum logic [1:0] {ER_SECTOR = 2'h0, ER_BLK32 = 2'h1, ER_BLK64 = 2'h2, ER_CHIP = 2'h3} qsfh_erase_e;
    localparam int PIN_IO0 = 0;
    localparam int PIN_IO1 = 1;
    localparam int PIN_IO2 = 2;
    localparam int PIN_IO3 = 3;
    localparam int PIN_SCLK = 4;
    localparam int PIN_CSN = 5;
    localparam logic [5:0] SYNC_RESET = 6'h00;
    localparam logic [7:0] OP_QPI_ENTER = 8'h38;
    localparam logic [7:0] OP_QPI_EXIT = 8'hFF;
    localparam logic [7:0] OP_SOFT_RESET = 8'h99;
    localparam logic [1:0] SRP_HW = 2'h1;
    localparam int ADDR_W = 19;
    localparam logic [19:0] MEM_BYTES = 20'h80000;
    localparam logic [4:0] SECTOR_LSB = 5'h0C;
    localparam logic [4:0] BLK32_LSB = 5'h0F;
    localparam logic [4:0] BLK64_LSB = 5'h10;
    localparam logic [4:0] CHIP_LSB = 5'h13;
    localparam logic [2:0] SEC_SHIFT_MAX = 3'h3;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam logic [63:0] UID_DEFAULT = 64'h0123456789ABCDEF;
endpackage

/* verif/qsfh_host_model.sv */
// Host controller model: serial clock, chip select and host side of the data lines
`timescale 1ns/1ps
module qsfh_host_model (
    input wire logic clk_sys,
    input wire logic [3:0] line_in,
    output logic serial_clk,
    output logic chip_sel_n,
    output logic [3:0] host_out,
    output logic [3:0] host_drv
);
    localparam int HALF = 8; // 64 ns period, well under both read clock limits
    // Select starts low, so the first frame needs a high phase first
    initial begin
        serial_clk = 1'b0;
        chip_sel_n = 1'b0;
        host_out = 4'hF;
        host_drv = 4'hC;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic low();
        serial_clk <= 1'b0;
        wait_clk(HALF);
    endtask
    task automatic pins(input logic [1:0] v);
        host_out[3:2] <= v;
        host_drv[3:2] <= 2'h3;
    endtask
    // Clock rests at the chosen level across select edges
    task automatic frame(input logic on, input logic idle);
        serial_clk <= idle;
        wait_clk(HALF);
        chip_sel_n <= 1'b1;
        wait_clk(2 * HALF);
        chip_sel_n <= !on;
        wait_clk(HALF);
    endtask
    // MSB first; a read releases lanes 0 to w-1 (line 0 alone in single mode), single reads come back on line 1
    task automatic xfer(input int w, input int n, input logic [7:0] dout, input logic drv, output logic [7:0] din);
        logic [3:0] m;
        m = 4'((1 << w) - 1);
        din = 8'h00;
        for (int i = n - w; i >= 0; i -= w) begin
            serial_clk <= 1'b0;
            host_out <= (host_out & ~m) | (4'(dout >> i) & m);
            host_drv <= drv ? (host_drv | m) : (host_drv & ~m);
            wait_clk(HALF);
            din = 8'((din << w) | ((w == 1 ? line_in >> 1 : line_in) & m));
            serial_clk <= 1'b1;
            wait_clk(HALF);
        end
    endtask
endmodule

/* verif/quad_serial_flash_host_interface_bench.sv */
// Self-checking bench for the serial flash interface front end
`timescale 1ns/1ps
module quad_serial_flash_host_interface_bench;
    import qsfh_pkg::*;
    localparam int PL = 4;
    localparam logic [63:0] UID = 64'h5A5A1234C3C30F0F; // Arbitrary value
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic pat = 1'b0;
    logic mon_on = 1'b1;
    wire serial_clk, chip_sel_n;
    wire [3:0] hout, hdrv, oe_n, dout;
    logic [3:0] line;
    logic quad_enable_bit = 1'b0, complement_bit = 1'b0, sector_granularity_bit = 1'b0, top_bottom_bit = 1'b0;
    logic block_protect_2 = 1'b0, block_protect_1 = 1'b0, block_protect_0 = 1'b0, tx_enable = 1'b0, prog_data = 1'b0;
    logic [1:0] status_protect_bits = 2'h0;
    logic [7:0] tx_data = 8'h00;
    logic [7:0] rx_data, uid_byte, d;
    logic [2:0] uid_index = 3'h0;
    logic [18:0] check_addr = 19'h00000;
    logic [18:0] erase_base;
    qsfh_lane_e lane_width = LANE_SINGLE;
    qsfh_erase_e erase_kind = ER_SECTOR;
    logic tx_taken, rx_valid, rx_is_opcode, selected, paused, quad_instruction_mode, frame_end, sr_write_ok;
    logic addr_protected;
    logic [8:0] prog_byte_count;
    int fail_count = 0;
    int compares = 0;
    int seed = 6;
    int exp_q[$];
    int ends = 0;
    int takes = 0;
    int mark = 0;

    always #2 clk_sys = ~clk_sys;
    // Released lines show a pattern that changes every cycle, never a remembered value
    always @(posedge clk_sys) pat <= ~pat;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            line[i] = !oe_n[i] ? dout[i] : hdrv[i] ? hout[i] : pat;
        end
    end

    qsfh_front #(.UID_VALUE(UID), .PROG_LIMIT(PL)) uut (
        .clk_sys, .reset_n, .serial_clk, .chip_sel_n,
        .io_line0_in(line[0]), .io_line0_out(dout[0]), .io_line0_oe_n(oe_n[0]),
        .io_line1_in(line[1]), .io_line1_out(dout[1]), .io_line1_oe_n(oe_n[1]),
        .io_line2_in(line[2]), .io_line2_out(dout[2]), .io_line2_oe_n(oe_n[2]),
        .io_line3_in(line[3]), .io_line3_out(dout[3]), .io_line3_oe_n(oe_n[3]),
        .quad_enable_bit, .status_protect_bits, .complement_bit, .sector_granularity_bit, .top_bottom_bit,
        .block_protect_2, .block_protect_1, .block_protect_0, .lane_width, .tx_enable, .tx_data, .tx_taken,
        .rx_data, .rx_valid, .rx_is_opcode, .prog_data, .prog_byte_count, .selected, .paused,
        .quad_instruction_mode, .frame_end, .sr_write_ok, .check_addr, .addr_protected, .erase_kind,
        .erase_base, .uid_index, .uid_byte
    );
    qsfh_host_model host (.clk_sys, .line_in(line), .serial_clk, .chip_sel_n, .host_out(hout), .host_drv(hdrv));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t mismatch: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d of %0d compares", fail_count, compares);
        if (fail_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic send(input logic op, input int w, input logic [7:0] b);
        exp_q.push_back({op, b});
        host.xfer(w, 8, b, 1'b1, d);
    endtask
    task automatic close(input logic idle);
        mark = ends;
        host.frame(1'b0, idle);
        check({selected, oe_n}, 5'h0F);
        check(ends - mark, 1);
    endtask
    function automatic logic exp_prot();
        int sz;
        int bp;
        int cap;
        bp = {block_protect_2, block_protect_1, block_protect_0};
        cap = sector_granularity_bit ? 32768 : 524288;
        sz = (sector_granularity_bit ? 4096 << bp : 65536 << bp) >> 1;
        if (sz > cap) sz = cap;
        if (bp == 0) sz = 0;
        return (top_bottom_bit ? check_addr < sz : check_addr >= 524288 - sz) ^ complement_bit;
    endfunction
    function automatic logic [18:0] exp_base();
        int l;
        l = erase_kind == ER_SECTOR ? 12 : erase_kind == ER_BLK32 ? 15 : erase_kind == ER_BLK64 ? 16 : 19;
        return 19'((int'(check_addr) >> l) << l);
    endfunction

    // Every received byte is matched against the queue; reads are skipped since the host releases its lanes then
    always @(posedge clk_sys) begin
        if (frame_end === 1'b1) ends++;
        if (tx_taken === 1'b1) takes++;
        if (rx_valid === 1'b1 && mon_on) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else check({rx_is_opcode, rx_data}, exp_q.pop_front());
        end
    end

    // Whole run needs well under 100 us; this bound only catches a hang
    initial begin
        #300000;
        fail_count++;
        summarize();
    end

    initial begin
        int k;
        int w;
        logic [7:0] op;
        step(2);
        check({addr_protected, sr_write_ok, oe_n}, 6'h2F);
        reset_n <= 1'b1;
        host.xfer(1, 8, 8'hA5, 1'b1, d);
        host.low();
        host.frame(1'b1, 1'b0);
        check(selected, 1'b1);
        send(1'b1, 1, 8'($random(seed)));
        prog_data <= 1'b1;
        for (k = 0; k < 6; k++) send(1'b0, 1, 8'($random(seed)));
        check(prog_byte_count, 9'(PL));
        prog_data <= 1'b0;
        close(1'b0);
        for (k = 0; k < 4; k++) begin
            quad_enable_bit <= (k == 2);
            lane_width <= qsfh_lane_e'(2'(k > 1 ? 2 : k));
            host.pins(2'h3);
            w = (k == 2) ? 4 : (k == 1) ? 2 : 1;
            host.frame(1'b1, k[0]);
            send(1'b1, 1, 8'h0B);
            op = 8'($random(seed));
            tx_data <= op;
            tx_enable <= 1'b1;
            mon_on <= 1'b0;
            takes = 0;
            host.xfer(w, 8, 8'h00, 1'b0, d);
            check(d, op);
            check(takes, 1);
            tx_enable <= 1'b0;
            close(k[0]);
            mon_on <= 1'b1;
        end
        for (k = 0; k < 4; k++) begin
            quad_enable_bit <= (k != 3);
            host.pins(2'h3);
            op = (k == 1) ? {2'h1, 6'($random(seed))} : (k == 2) ? OP_QPI_EXIT : OP_QPI_ENTER;
            host.frame(1'b1, 1'b0);
            send(1'b1, (k == 1 || k == 2) ? 4 : 1, op);
            close(1'b0);
            check(quad_instruction_mode, k < 2);
        end
        op = 8'($random(seed));
        host.frame(1'b1, 1'b0);
        exp_q.push_back({1'b1, op});
        host.xfer(1, 4, op >> 4, 1'b1, d);
        host.low();
        host.pins(2'h1);
        step(8);
        check({paused, oe_n}, 5'h1F);
        host.xfer(1, 4, ~op, 1'b1, d);
        host.low();
        host.pins(2'h3);
        step(8);
        check(paused, 1'b0);
        host.xfer(1, 4, op, 1'b1, d);
        close(1'b0);
        host.frame(1'b1, 1'b1);
        host.xfer(1, 5, 8'h15, 1'b1, d);
        close(1'b1);
        host.frame(1'b1, 1'b0);
        send(1'b1, 1, 8'h5C);
        close(1'b0);
        for (k = 0; k < 16; k++) begin
            status_protect_bits <= k[1:0];
            quad_enable_bit <= k[3];
            host.pins({1'b1, k[2]});
            step(6);
            check(sr_write_ok, !(k[1:0] == SRP_HW && !k[2] && !k[3]));
        end
        for (k = 0; k < 300; k++) begin
            {complement_bit, sector_granularity_bit, top_bottom_bit} <= 3'($random(seed));
            {block_protect_2, block_protect_1, block_protect_0} <= 3'($random(seed));
            check_addr <= 19'($random(seed));
            erase_kind <= qsfh_erase_e'(2'($random(seed)));
            uid_index <= 3'($random(seed));
            step(3);
            check(addr_protected, exp_prot());
            check(erase_base, exp_base());
            check(uid_byte, 8'(UID >> (8 * uid_index)));
        end
        check(exp_q.size(), 0);
        summarize();
    end
endmodule
